// file: dcau_pkg.sv
// dcau_pkg: constants of the count/address update block
// assumes one clock domain and the plain register port of dcau_top
package dcau_pkg;
   localparam int ADDR_W = 18;
   localparam int CNT_W  = 16;
   localparam int SEL_W  = 3;
   localparam int RA_W   = 4;
   localparam int DW     = 32;

   // register byte offsets
   localparam logic [RA_W-1:0] OFS_CTRL  = 4'h0;
   localparam logic [RA_W-1:0] OFS_DATA  = 4'h4;
   localparam logic [RA_W-1:0] OFS_WORD  = 4'h8;
   localparam logic [RA_W-1:0] OFS_STAT  = 4'hc;

   // control register fields
   localparam int CTRL_SEL_LO = 8;
   localparam int CTRL_SEL_HI = 10;
   localparam int CTRL_CODE_HI = 11;
   localparam int CTRL_EXT    = 12;

   // status register fields
   localparam int STAT_BUSY   = 0;
   localparam int STAT_BYPASS = 1;
   localparam int STAT_MASTER = 2;

   // reset values
   localparam logic [SEL_W-1:0]  SEL_RST  = 3'h0;
   localparam logic [ADDR_W-1:0] DATA_RST = 18'h00000;

   // selector codes: bit2 secondary, bit1 transmit, bit0 count word
   localparam logic [SEL_W-1:0] SEL_RX_BA_P = 3'h0;
   localparam logic [SEL_W-1:0] SEL_RX_CC_P = 3'h1;
   localparam logic [SEL_W-1:0] SEL_TX_BA_P = 3'h2;
   localparam logic [SEL_W-1:0] SEL_TX_CC_P = 3'h3;
   localparam logic [SEL_W-1:0] SEL_RX_BA_S = 3'h4;
   localparam logic [SEL_W-1:0] SEL_RX_CC_S = 3'h5;
   localparam logic [SEL_W-1:0] SEL_TX_BA_S = 3'h6;
   localparam logic [SEL_W-1:0] SEL_TX_CC_S = 3'h7;

   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_FETCH   = 3'b001,
      ST_PRELOAD = 3'b011,
      ST_CLOCK   = 3'b010,
      ST_STORE   = 3'b110
   } dcau_state_t;
endpackage

// file: dcau_store.sv
// dcau_store: eight 18-bit address/count words
// low 16 bits and upper 2 bits have separate write enables; read data registered
`timescale 1ns/100ps
`default_nettype none
module dcau_store
   import dcau_pkg::*;
(
   input  wire logic              clock,
   input  wire logic [SEL_W-1:0]  addr,
   input  wire logic [ADDR_W-1:0] wdata,
   input  wire logic              we_low,
   input  wire logic              we_high,
   output logic      [ADDR_W-1:0] rdata_q
);
   logic [ADDR_W-1:0] mem [0:7];

   always_ff @(posedge clock) begin
      if (we_low) begin
         mem[addr][CNT_W-1:0] <= wdata[CNT_W-1:0];
      end
      if (we_high) begin
         mem[addr][ADDR_W-1:CNT_W] <= wdata[ADDR_W-1:CNT_W];
      end
   end

   // contents are not cleared by reset, as in a plain ram
   always_ff @(posedge clock) begin
      rdata_q <= mem[addr];
   end
endmodule
`default_nettype wire

// file: dcau_counter.sv
// dcau_counter: 18-bit preloadable up counter
// preload wins over the count strobe if both come at once
`timescale 1ns/100ps
`default_nettype none
module dcau_counter
   import dcau_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic              preload,
   input  wire logic              count,
   input  wire logic [ADDR_W-1:0] din,
   output logic      [ADDR_W-1:0] q
);
   always_ff @(posedge clock) begin
      if (rst) begin
         q <= DATA_RST;
      end else if (preload) begin
         q <= din;
      end else if (count) begin
         q <= q + 18'h00001;
      end
   end
endmodule
`default_nettype wire

// file: dcau_top.sv
// dcau_top: address and character count words of a dma line interface
// assumes bus inputs synchronous to clock; update starts come from sequencing logic
//
// Summary of operation
// - outside update cycle, storage word address comes from selector bits 10..8, or from the transfer's address word while bus master outside a load pulse
// - outside update cycle, storage write data is the bus data value
// - writing selector code bits 10..8 while no update runs makes a load pulse into chosen word
// - with extended bit 12 set, address bits 16 and 17 also load
// - selected word shows after load; address drives bus only as master
// - code 2 holds transmit primary address, code 3 transmit primary count
// - stored count word can be read back by software
// - only whole words at even addresses; address bit 0 stays zero
// - update: preload counter from word, clock once, write result back
// - address update forces counter preload bit 0 to one, net plus two
// - address update ignores single/double character size
// - after each transfer counter steps once; new address used next cycle
// - bit 0 write-back uses bypass flag only for odd count plus two
// - codes: 0 rx addr, 1 rx count, 2 tx addr, 3 tx count, 4..7 secondary
`timescale 1ns/100ps
`default_nettype none
module dcau_top
   import dcau_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [RA_W-1:0]   reg_addr,
   input  wire logic [DW-1:0]     reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DW-1:0]     reg_rdata_q,
   input  wire logic              update_start,
   input  wire logic              update_count,
   input  wire logic              xfer_tx,
   input  wire logic              xfer_secondary,
   input  wire logic              double_char,
   input  wire logic              bus_master,
   output logic      [ADDR_W-1:0] bus_addr_q,
   output logic                   bus_addr_oe_q,
   output logic                   update_cycle_flag_q,
   output logic                   update_done_q
);
   // composes the storage word index from cycle attributes
   function automatic logic [SEL_W-1:0] word_code(
      input logic secondary,
      input logic tx,
      input logic is_count
   );
      word_code = {secondary, tx, is_count};
   endfunction

   // forces address bit 0 low for every bus word
   function automatic logic [ADDR_W-1:0] even_word(
      input logic [ADDR_W-1:0] a
   );
      even_word = {a[ADDR_W-1:1], 1'b0};
   endfunction

   dcau_state_t       state_q;
   dcau_state_t       state_d;
   logic [SEL_W-1:0]  sel_q;
   logic              ext_q;
   logic [ADDR_W-1:0] data_q;
   logic              storage_load_pulse_q;
   logic              upper_address_load_q;
   logic              is_count_q;
   logic              dbl_q;
   logic              tx_q;
   logic              sec_q;
   logic              odd_count_bypass_flag_q;
   logic              master_q;
   logic              counter_preload;
   logic              counter_clock_strobe;
   logic [SEL_W-1:0]  mem_addr;
   logic [ADDR_W-1:0] mem_wdata;
   logic              mem_we_low;
   logic              mem_we_high;
   logic [ADDR_W-1:0] mem_rdata;
   logic [ADDR_W-1:0] cnt_din;
   logic [ADDR_W-1:0] cnt_q;
   logic [ADDR_W-1:0] result;
   logic              wr_ctrl;
   logic              start_ok;

   assign wr_ctrl  = reg_wr && (reg_addr == OFS_CTRL);
   // a start during a pending load is dropped; sequencer must not overlap them
   assign start_ok = update_start && (state_q == ST_IDLE) && !storage_load_pulse_q;

   // sequencing of one update
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (start_ok) begin
               state_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_d = ST_PRELOAD;
         end
         ST_PRELOAD: begin
            state_d = ST_CLOCK;
         end
         ST_CLOCK: begin
            state_d = ST_STORE;
         end
         ST_STORE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         update_cycle_flag_q <= 1'b0;
      end else begin
         update_cycle_flag_q <= (state_d != ST_IDLE);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         update_done_q <= 1'b0;
      end else begin
         update_done_q <= (state_q == ST_STORE);
      end
   end

   // attributes of the word being updated, caught at start
   always_ff @(posedge clock) begin
      if (rst) begin
         is_count_q <= 1'b0;
         dbl_q      <= 1'b0;
         tx_q       <= 1'b0;
         sec_q      <= 1'b0;
      end else if (start_ok) begin
         is_count_q <= update_count;
         dbl_q      <= double_char && update_count;
         tx_q       <= xfer_tx;
         sec_q      <= xfer_secondary;
      end
   end

   // control register: selector and extended memory bit
   always_ff @(posedge clock) begin
      if (rst) begin
         sel_q <= SEL_RST;
         ext_q <= 1'b0;
      end else if (wr_ctrl) begin
         sel_q <= reg_wdata[CTRL_SEL_HI:CTRL_SEL_LO];
         ext_q <= reg_wdata[CTRL_EXT];
      end
   end

   // value that software wants to load, bus data lines
   always_ff @(posedge clock) begin
      if (rst) begin
         data_q <= DATA_RST;
      end else if (reg_wr && (reg_addr == OFS_DATA)) begin
         data_q <= reg_wdata[ADDR_W-1:0];
      end
   end

   // load pulse one cycle after the code write; refused while updating
   always_ff @(posedge clock) begin
      if (rst) begin
         storage_load_pulse_q <= 1'b0;
         upper_address_load_q <= 1'b0;
      end else begin
         storage_load_pulse_q <= wr_ctrl && (state_q == ST_IDLE);
         // count words never take upper bits, so they stay 16-bit words
         upper_address_load_q <= wr_ctrl && (state_q == ST_IDLE)
                                 && reg_wdata[CTRL_EXT] && !reg_wdata[CTRL_SEL_LO];
      end
   end

   // storage address: cycle word inside the cycle, transfer address word as master outside a load pulse, else selector
   always_comb begin
      if (state_q != ST_IDLE) begin
         mem_addr = word_code(sec_q, tx_q, is_count_q);
      end else if (bus_master && !storage_load_pulse_q) begin
         mem_addr = word_code(xfer_secondary, xfer_tx, 1'b0);
      end else begin
         mem_addr = sel_q;
      end
   end

   // bit 0 restore path
   always_comb begin
      result = cnt_q;
      if (is_count_q && dbl_q && odd_count_bypass_flag_q) begin
         result[0] = odd_count_bypass_flag_q;
      end
      if (is_count_q) begin
         result[ADDR_W-1:CNT_W] = 2'h0;
      end
   end

   // write data: bus data outside the cycle, counter result inside it
   always_comb begin
      if (state_q != ST_IDLE) begin
         mem_wdata   = result;
         mem_we_low  = (state_q == ST_STORE);
         mem_we_high = (state_q == ST_STORE) && !is_count_q;
      end else begin
         mem_wdata   = data_q;
         mem_we_low  = storage_load_pulse_q;
         mem_we_high = upper_address_load_q;
      end
   end

   // preload input: address words force bit 0 high for a plus-two step
   always_comb begin
      cnt_din = mem_rdata;
      if (!is_count_q || dbl_q) begin
         cnt_din[0] = 1'b1;
      end
   end

   assign counter_preload      = (state_q == ST_PRELOAD);
   assign counter_clock_strobe = (state_q == ST_CLOCK);

   // remembers an odd stored count for the plus-two write-back
   always_ff @(posedge clock) begin
      if (rst) begin
         odd_count_bypass_flag_q <= 1'b0;
      end else if (counter_preload) begin
         odd_count_bypass_flag_q <= is_count_q && mem_rdata[0];
      end
   end

   dcau_store u_store (
      .clock   (clock),
      .addr    (mem_addr),
      .wdata   (mem_wdata),
      .we_low  (mem_we_low),
      .we_high (mem_we_high),
      .rdata_q (mem_rdata)
   );

   dcau_counter u_counter (
      .clock   (clock),
      .rst     (rst),
      .preload (counter_preload),
      .count   (counter_clock_strobe),
      .din     (cnt_din),
      .q       (cnt_q)
   );

   // bus address lines: word one cycle behind the storage read
   always_ff @(posedge clock) begin
      if (rst) begin
         master_q <= 1'b0;
      end else begin
         master_q <= bus_master && (state_q == ST_IDLE);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         bus_addr_q    <= DATA_RST;
         bus_addr_oe_q <= 1'b0;
      end else begin
         bus_addr_oe_q <= master_q && bus_master;
         if (master_q) begin
            bus_addr_q <= even_word(mem_rdata);
         end
      end
   end

   // register reads, data in the cycle after the strobe
   always_ff @(posedge clock) begin
      if (rst) begin
         reg_rdata_q <= 32'h00000000;
      end else if (reg_rd) begin
         reg_rdata_q <= 32'h00000000;
         unique case (reg_addr)
            OFS_CTRL: begin
               reg_rdata_q[CTRL_SEL_HI:CTRL_SEL_LO] <= sel_q;
               reg_rdata_q[CTRL_EXT]                <= ext_q;
            end
            OFS_DATA: begin
               reg_rdata_q[ADDR_W-1:0] <= data_q;
            end
            OFS_WORD: begin
               // upper bits of a count word are never written, so they are hidden
               reg_rdata_q[ADDR_W-1:0] <= sel_q[0] ? {2'h0, mem_rdata[CNT_W-1:0]} : mem_rdata;
            end
            OFS_STAT: begin
               reg_rdata_q[STAT_BUSY]   <= (state_q != ST_IDLE);
               reg_rdata_q[STAT_BYPASS] <= odd_count_bypass_flag_q;
               reg_rdata_q[STAT_MASTER] <= bus_addr_oe_q;
            end
            default: begin
               reg_rdata_q <= 32'h00000000;
            end
         endcase
      end else begin
         reg_rdata_q <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// file: dcau_top_checker.sv
// dcau_top_checker: port-level assertions for dcau_top
// assumes one clock domain, reset synchronous and active high
`timescale 1ns/100ps
`default_nettype none
module dcau_top_checker
   import dcau_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [RA_W-1:0]   reg_addr,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   input  wire logic [DW-1:0]     reg_rdata_q,
   input  wire logic              update_start,
   input  wire logic              bus_master,
   input  wire logic [ADDR_W-1:0] bus_addr_q,
   input  wire logic              bus_addr_oe_q,
   input  wire logic              update_cycle_flag_q,
   input  wire logic              update_done_q
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence busy_run_s;
      update_cycle_flag_q [*4];
   endsequence
   sequence finish_s;
      !update_cycle_flag_q && update_done_q;
   endsequence

   update_walk_a: assert property ($rose(update_cycle_flag_q) |-> busy_run_s ##1 finish_s)
      else $error("update walk has wrong length");
   // a start in the load pulse cycle is refused, so it is left out here
   start_take_a: assert property (update_start && !update_cycle_flag_q && !update_done_q && !reg_wr
      && !$past(reg_wr && reg_addr == OFS_CTRL) |=> update_cycle_flag_q)
      else $error("idle update start not taken");
   done_walk_a: assert property (update_done_q |-> $past(update_cycle_flag_q) ##1 !update_done_q)
      else $error("done pulse misplaced");
   addr_even_a: assert property (bus_addr_q[0] == 1'b0)
      else $error("odd bus address");
   oe_master_a: assert property (bus_addr_oe_q |-> $past(bus_master))
      else $error("address driven without mastership");
   oe_drop_a: assert property ($fell(bus_master) |=> !bus_addr_oe_q)
      else $error("address enable late to drop");
   oe_rise_a: assert property ($rose(bus_master) && !update_cycle_flag_q |-> ##[1:2] bus_addr_oe_q)
      else $error("address enable late to rise");
   rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
      else $error("read data outside read answer");
endmodule

bind dcau_top dcau_top_checker dcau_top_checker_inst (
   .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata_q(reg_rdata_q), .update_start(update_start), .bus_master(bus_master),
   .bus_addr_q(bus_addr_q), .bus_addr_oe_q(bus_addr_oe_q),
   .update_cycle_flag_q(update_cycle_flag_q), .update_done_q(update_done_q));
`default_nettype wire

// file: dcau_bus_mem.sv
// dcau_bus_mem: system bus side, grants mastership and latches the address
// assumes the address is valid two cycles after mastership starts
`timescale 1ns/100ps
`default_nettype none
module dcau_bus_mem
   import dcau_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              req,
   input  wire logic [ADDR_W-1:0] bus_addr_q,
   input  wire logic              bus_addr_oe_q,
   output logic                   bus_master,
   output logic      [ADDR_W-1:0] seen_q
);
   logic [2:0] cnt_q = 3'h0;

   always_ff @(posedge clock) begin
      if (req) begin
         cnt_q <= 3'h4;
      end else if (cnt_q != 3'h0) begin
         cnt_q <= cnt_q - 3'h1;
      end
      // undriven address lines float up to all ones through the terminators
      if (cnt_q == 3'h1) begin
         seen_q <= bus_addr_oe_q ? bus_addr_q : 18'h3_ffff;
      end
   end
   assign bus_master = (cnt_q != 3'h0);
endmodule
`default_nettype wire

// file: dcau_top_tb.sv
// dcau_top_tb: register port tests of the address/count words and their update
// assumes dcau_bus_mem stands on the system bus side
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %0t mismatch got %h want %h", $time, (g), (e)); end end
module dcau_top_tb
   import dcau_pkg::*;
;
   logic              clock = 1'b0;
   logic              rst = 1'b1;
   logic [RA_W-1:0]   reg_addr = 4'h0;
   logic [DW-1:0]     reg_wdata = 32'h0;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [DW-1:0]     reg_rdata_q;
   logic              update_start = 1'b0;
   logic              update_count = 1'b0;
   logic              xfer_tx = 1'b0;
   logic              xfer_secondary = 1'b0;
   logic              double_char = 1'b0;
   logic              bus_master;
   logic [ADDR_W-1:0] bus_addr_q;
   logic              bus_addr_oe_q;
   logic              update_cycle_flag_q;
   logic              update_done_q;
   logic              req = 1'b0;
   logic [ADDR_W-1:0] seen_q;
   logic [ADDR_W-1:0] w;
   int                bad_count = 0;
   int                cmp_count = 0;

   always #12.5 clock = ~clock;

   dcau_top dcau_top_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .update_start(update_start),
      .update_count(update_count), .xfer_tx(xfer_tx), .xfer_secondary(xfer_secondary),
      .double_char(double_char), .bus_master(bus_master), .bus_addr_q(bus_addr_q),
      .bus_addr_oe_q(bus_addr_oe_q), .update_cycle_flag_q(update_cycle_flag_q),
      .update_done_q(update_done_q));
   dcau_bus_mem dcau_bus_mem_inst (.clock(clock), .req(req), .bus_addr_q(bus_addr_q),
      .bus_addr_oe_q(bus_addr_oe_q), .bus_master(bus_master), .seen_q(seen_q));

   function automatic logic [ADDR_W-1:0] v(input int i);
      return 18'h3_fff0 - ADDR_W'(i * 16);
   endfunction
   task automatic wr(input logic [RA_W-1:0] a, input logic [DW-1:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [RA_W-1:0] a, input logic [DW-1:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      `CHK(reg_rdata_q, e)
   endtask
   task automatic ld(input logic [SEL_W-1:0] s, input logic [ADDR_W-1:0] d, input logic x);
      wr(OFS_DATA, {14'h0, d});
      wr(OFS_CTRL, {19'h0, x, 1'b0, s, 8'h0});
      // registered storage read shows the new word one cycle after the load pulse
      @(posedge clock);
   endtask
   task automatic upd(input logic c, input logic t, input logic s, input logic dbl);
      @(posedge clock);
      update_start <= 1'b1;
      update_count <= c;
      xfer_tx <= t;
      xfer_secondary <= s;
      double_char <= dbl;
      @(posedge clock);
      update_start <= 1'b0;
      repeat (3) @(posedge clock);
      @(negedge clock);
      `CHK(update_done_q, 1'b0)
      @(negedge clock);
      `CHK(update_done_q, 1'b1)
   endtask
   task automatic bus(input logic t, input logic s, input logic [ADDR_W-1:0] e);
      @(posedge clock);
      req <= 1'b1;
      xfer_tx <= t;
      xfer_secondary <= s;
      @(posedge clock);
      req <= 1'b0;
      repeat (5) @(posedge clock);
      @(negedge clock);
      `CHK(seen_q, e)
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      @(negedge clock);
      `CHK({reg_rdata_q, bus_addr_oe_q, update_cycle_flag_q}, 34'h0)
      rd(OFS_STAT, 32'h0);
      // count words get the two's complement of the wanted count
      for (int i = 0; i < 8; i++) begin
         w = v(i);
         ld(i[2:0], w, 1'b1);
         rd(OFS_WORD, i[0] ? {16'h0, w[15:0]} : {14'h0, w});
      end
      for (int j = 0; j < 4; j++) begin
         bus(j[0], j[1], v(2 * j));
      end
      ld(3'h2, 18'h0_0010, 1'b0);
      rd(OFS_WORD, 32'h3_0010);
      upd(1'b0, 1'b1, 1'b0, 1'b1);
      rd(OFS_WORD, 32'h3_0012);
      ld(3'h2, 18'h0_fffe, 1'b1);
      upd(1'b0, 1'b1, 1'b0, 1'b0);
      rd(OFS_WORD, 32'h1_0000);
      bus(1'b1, 1'b0, 18'h1_0000);
      for (int k = 0; k < 4; k++) begin
         ld(3'h3, 18'h0_fff0 | 18'(k[0]), 1'b1);
         upd(1'b1, 1'b1, 1'b0, k[1]);
         rd(OFS_WORD, 32'h0_fff1 + 32'(k[0]) + 32'(k[1]));
      end
      rd(OFS_STAT, 32'h0000_0002);
      wr(4'h2, 32'hffff_ffff);
      rd(4'h2, 32'h0);
      rd(4'h6, 32'h0);
      rd(OFS_CTRL, 32'h0000_1300);
      rd(OFS_DATA, 32'h0000_fff1);
      conclude();
   end

   initial begin
      repeat (3000) @(posedge clock);
      bad_count++;
      conclude();
   end
endmodule
`default_nettype wire
